// ==== rtl/link_test_defs.svh ====
// Register map, field positions, reset values and constants of the link self-test block
// Assumes an 8-bit register port with byte-wide registers
`ifndef LINK_TEST_DEFS_SVH
`define LINK_TEST_DEFS_SVH

`define REG_ERROR_TALLY_CONTROL   8'h1E
`define REG_BIT_ERROR_TALLY       8'h1F
`define REG_LINK_TEST_CONTROL     8'h20
`define REG_MISMATCH_BYTE0        8'h21
`define REG_MISMATCH_BYTE1        8'h22
`define REG_MISMATCH_BYTE2        8'h23
`define REG_MISMATCH_BYTE3        8'h24

`define RESET_ERROR_TALLY_CONTROL 8'h00
`define RESET_LINK_TEST_CONTROL   8'h00
`define RESET_BIT_ERROR_TALLY     8'h00
`define RESET_MISMATCH_COUNT      32'h00000000

`define ETC_HEADER_COUNT_BIT      0
`define ETC_DECODE_BIT            1
`define ETC_CRC_BIT               2
`define ETC_PARITY_BIT            3
`define ETC_INTERRUPT_CRC_BIT     4
`define ETC_THRESHOLD_MSB         7
`define ETC_THRESHOLD_LSB         5

`define LTC_UPSTREAM_PATTERN_BIT  0
`define LTC_DOWNSTREAM_PATTERN_BIT 1
`define LTC_PER_HOP_CHECK_BIT     2
`define LTC_FIFO_DEPTH_MSB        5
`define LTC_FIFO_DEPTH_LSB        4

`define TALLY_THRESHOLD_BASE      9'h002
`define PRBS_SEED                 31'h7FFFFFFF
`define SLOT_WINDOW_MAX           9'h0FF

`endif

// ==== rtl/link_test_pkg.sv ====
// Types shared by the link self-test block
// Assumes nothing of its surroundings
package link_test_pkg;
    typedef logic [7:0]  reg_byte_t;
    typedef logic [31:0] slot_word_t;
    typedef logic [30:0] prbs_state_t;
    typedef logic [31:0] mismatch_count_t;
endpackage : link_test_pkg

// ==== rtl/prbs_generator.sv ====
// Pseudo-random slot word source, x^31 + x^28 + 1, 32 bits per step
// Assumes advance and restart are synchronous to clock_i
`timescale 1ns/1ps
`include "link_test_defs.svh"

module prbs_generator
    import link_test_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    input  wire logic       restart_i,
    input  wire logic       advance_i,
    output slot_word_t      word_o
);
    prbs_state_t state;
    slot_word_t  next_word;
    prbs_state_t next_state;

    function automatic logic [62:0] prbs_step(input prbs_state_t s);
        prbs_state_t st;
        slot_word_t  w;
        logic        fb;
        st = s;
        w  = 32'h00000000;
        for (int i = 0; i < 32; i++) begin
            fb = st[30] ^ st[27];
            st = {st[29:0], fb};
            w  = {w[30:0], fb};
        end
        return {st, w};
    endfunction : prbs_step

    assign {next_state, next_word} = prbs_step(state);

    always_ff @(posedge clock_i) begin
        if (!nrst_i || restart_i) begin
            state  <= `PRBS_SEED;
            word_o <= 32'h00000000;
        end else if (advance_i) begin
            state  <= next_state;
            word_o <= next_word;
        end
    end
endmodule : prbs_generator

// ==== rtl/saturating_counter.sv ====
// Up counter that saturates at all ones; clear restarts it from the same-cycle increment
// Assumes clear and increment are synchronous to clock_i
`timescale 1ns/1ps

module saturating_counter #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock_i,
    input  wire logic             nrst_i,
    input  wire logic             clear_i,
    input  wire logic [2:0]       inc_i,
    output logic      [WIDTH-1:0] count_o
);
    logic [WIDTH-1:0] base;
    logic [WIDTH:0]   sum;
    logic [WIDTH-1:0] next_count;

    // Event in the clear cycle still counts
    assign base       = clear_i ? '0 : count_o;
    assign sum        = {1'b0, base} + {{(WIDTH - 2){1'b0}}, inc_i};
    assign next_count = sum[WIDTH] ? '1 : sum[WIDTH-1:0];

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            count_o <= '0;
        end else begin
            count_o <= next_count;
        end
    end
endmodule : saturating_counter

// ==== rtl/link_test_block.sv ====
// Bit error tally and pseudo-random link test with mismatch counting
// Assumes single-cycle register strobes and one slot strobe per slot word
//
// Summary of operation
// - 8-bit tally counts every error of each type enabled in tally control.
// - Any write to the tally register clears it, whatever the data.
// - Bit 1 puts pattern data downstream, bit 0 puts it upstream.
// - Last subordinate checks downstream pattern within the programmed slot counts.
// - Main node checks the pattern data received in upstream slots.
// - Every pattern mismatch at a checking node bumps the 32-bit counter.
// - Per-hop mode: every node but the originating one checks input and forwards the expected pattern.
// - Per-hop mode does nothing unless some pattern enable is set.
// - Depth field 0 keeps depth, 1 adds one, 2 or 3 add two.
// - Mismatch count readable as four bytes, least significant byte first.
// - Mismatch count bytes are read-only; writes leave the count alone.
// - Threshold field picks 2 to 256 tallied errors for the overflow flag.
// - Parity tally enable counts streaming data parity errors.
// - CRC tally enable counts control and response frame CRC errors only.
// - Decode and header-count enables count their own error kinds.
`timescale 1ns/1ps
`include "link_test_defs.svh"

module link_test_block
    import link_test_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_write_i,
    input  wire logic       reg_read_i,
    input  wire reg_byte_t  reg_wdata_i,
    output reg_byte_t       reg_rdata_o,
    input  wire logic       main_node_i,
    input  wire logic       last_node_i,
    input  wire logic [7:0] downstream_slot_count_i,
    input  wire logic [7:0] local_downstream_slot_count_i,
    input  wire logic [7:0] broadcast_downstream_slot_count_i,
    input  wire logic       parity_error_i,
    input  wire logic       crc_error_i,
    input  wire logic       interrupt_crc_error_i,
    input  wire logic       decode_error_i,
    input  wire logic       header_count_error_i,
    output logic            tally_overflow_flag_o,
    output logic [1:0]      recovery_fifo_extra_depth_o,
    input  wire logic       dn_slot_strobe_i,
    input  wire logic [7:0] dn_slot_index_i,
    input  wire slot_word_t dn_rx_data_i,
    input  wire slot_word_t dn_local_data_i,
    output slot_word_t      dn_tx_data_o,
    input  wire logic       up_slot_strobe_i,
    input  wire slot_word_t up_rx_data_i,
    input  wire slot_word_t up_local_data_i,
    output slot_word_t      up_tx_data_o
);
    reg_byte_t       error_tally_control;
    reg_byte_t       link_test_control;
    reg_byte_t       bit_error_tally;
    mismatch_count_t pattern_mismatch_count;

    function automatic logic [8:0] slot_window(input logic [7:0] a, input logic [7:0] b,
                                               input logic [7:0] c);
        logic [9:0] s;
        s = {2'b00, a} + {2'b00, b} + {2'b00, c};
        return (s > {1'b0, `SLOT_WINDOW_MAX}) ? `SLOT_WINDOW_MAX : s[8:0];
    endfunction : slot_window

    // Register decode
    wire wr_control   = reg_write_i && (reg_addr_i == `REG_ERROR_TALLY_CONTROL);
    wire wr_tally     = reg_write_i && (reg_addr_i == `REG_BIT_ERROR_TALLY);
    wire wr_test      = reg_write_i && (reg_addr_i == `REG_LINK_TEST_CONTROL);

    // Field views
    wire downstream_pattern_enable = link_test_control[`LTC_DOWNSTREAM_PATTERN_BIT];
    wire upstream_pattern_enable   = link_test_control[`LTC_UPSTREAM_PATTERN_BIT];
    wire any_pattern               = downstream_pattern_enable || upstream_pattern_enable;
    wire per_hop_check_enable      = link_test_control[`LTC_PER_HOP_CHECK_BIT]
                                     && any_pattern;
    wire [1:0] depth_field = link_test_control[`LTC_FIFO_DEPTH_MSB:`LTC_FIFO_DEPTH_LSB];
    wire [1:0] next_depth  = depth_field[1] ? 2'h2 : depth_field;
    wire [2:0] threshold_sel =
        error_tally_control[`ETC_THRESHOLD_MSB:`ETC_THRESHOLD_LSB];

    // Enabled error events
    wire count_parity = parity_error_i && error_tally_control[`ETC_PARITY_BIT];
    wire count_crc    = crc_error_i && error_tally_control[`ETC_CRC_BIT];
    wire count_icrc   = interrupt_crc_error_i
                        && error_tally_control[`ETC_INTERRUPT_CRC_BIT];
    wire count_decode = decode_error_i && error_tally_control[`ETC_DECODE_BIT];
    wire count_header = header_count_error_i
                        && error_tally_control[`ETC_HEADER_COUNT_BIT];
    wire [2:0] tally_inc = {2'b00, count_parity} + {2'b00, count_crc}
                         + {2'b00, count_icrc} + {2'b00, count_decode}
                         + {2'b00, count_header};

    // Overflow threshold crossing
    wire [8:0] tally_threshold = `TALLY_THRESHOLD_BASE << threshold_sel;
    wire [8:0] tally_base      = wr_tally ? 9'h000 : {1'b0, bit_error_tally};
    wire [8:0] tally_sum       = tally_base + {6'h00, tally_inc};
    wire next_overflow = (tally_base < tally_threshold)
                         && (tally_sum >= tally_threshold);

    // Downstream roles
    wire [8:0] dn_window = slot_window(downstream_slot_count_i,
                                       local_downstream_slot_count_i,
                                       broadcast_downstream_slot_count_i);
    wire dn_in_window  = {1'b0, dn_slot_index_i} < dn_window;
    wire dn_originate  = downstream_pattern_enable && main_node_i;
    wire dn_check_role = downstream_pattern_enable && !main_node_i
                         && (last_node_i || per_hop_check_enable);
    wire dn_step       = dn_slot_strobe_i && dn_in_window
                         && (dn_originate || dn_check_role);
    wire dn_run        = dn_originate || dn_check_role;
    slot_word_t dn_expected;

    // Upstream roles
    wire up_originate  = upstream_pattern_enable && last_node_i && !main_node_i;
    wire up_check_role = upstream_pattern_enable
                         && (main_node_i || (per_hop_check_enable && !last_node_i));
    wire up_step       = up_slot_strobe_i && (up_originate || up_check_role);
    wire up_run        = up_originate || up_check_role;
    slot_word_t up_expected;

    // Mismatch detection
    wire dn_mismatch = dn_step && dn_check_role && (dn_rx_data_i != dn_expected);
    wire up_mismatch = up_step && up_check_role && (up_rx_data_i != up_expected);
    wire [2:0] mismatch_inc = {2'b00, dn_mismatch} + {2'b00, up_mismatch};

    // Transmit selection
    slot_word_t next_dn_tx;
    slot_word_t next_up_tx;
    assign next_dn_tx = dn_step ? dn_expected :
                        downstream_pattern_enable ? dn_rx_data_i : dn_local_data_i;
    assign next_up_tx = up_step ? up_expected :
                        (upstream_pattern_enable && !last_node_i) ? up_rx_data_i
                                                                  : up_local_data_i;

    // Read mux
    reg_byte_t next_rdata;
    assign next_rdata =
        (reg_addr_i == `REG_ERROR_TALLY_CONTROL) ? error_tally_control :
        (reg_addr_i == `REG_BIT_ERROR_TALLY)     ? bit_error_tally :
        (reg_addr_i == `REG_LINK_TEST_CONTROL)   ? link_test_control :
        (reg_addr_i == `REG_MISMATCH_BYTE0)      ? pattern_mismatch_count[7:0] :
        (reg_addr_i == `REG_MISMATCH_BYTE1)      ? pattern_mismatch_count[15:8] :
        (reg_addr_i == `REG_MISMATCH_BYTE2)      ? pattern_mismatch_count[23:16] :
        (reg_addr_i == `REG_MISMATCH_BYTE3)      ? pattern_mismatch_count[31:24] :
        8'h00;

    prbs_generator dn_pattern (
        .clock_i   (clock_i),
        .nrst_i    (nrst_i),
        .restart_i (!dn_run),
        .advance_i (dn_step),
        .word_o    (dn_expected)
    );

    prbs_generator up_pattern (
        .clock_i   (clock_i),
        .nrst_i    (nrst_i),
        .restart_i (!up_run),
        .advance_i (up_step),
        .word_o    (up_expected)
    );

    saturating_counter #(.WIDTH(8)) tally_counter (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .clear_i (wr_tally),
        .inc_i   (tally_inc),
        .count_o (bit_error_tally)
    );

    // No clear input reachable from software
    saturating_counter #(.WIDTH(32)) mismatch_counter (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .clear_i (1'b0),
        .inc_i   (mismatch_inc),
        .count_o (pattern_mismatch_count)
    );

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            error_tally_control <= `RESET_ERROR_TALLY_CONTROL;
            link_test_control   <= `RESET_LINK_TEST_CONTROL;
        end else begin
            if (wr_control) begin
                error_tally_control <= reg_wdata_i;
            end
            if (wr_test) begin
                link_test_control <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            reg_rdata_o                 <= 8'h00;
            tally_overflow_flag_o       <= 1'b0;
            recovery_fifo_extra_depth_o <= 2'h0;
            dn_tx_data_o                <= 32'h00000000;
            up_tx_data_o                <= 32'h00000000;
        end else begin
            if (reg_read_i) begin
                reg_rdata_o <= next_rdata;
            end
            tally_overflow_flag_o       <= next_overflow;
            recovery_fifo_extra_depth_o <= next_depth;
            if (dn_slot_strobe_i) begin
                dn_tx_data_o <= next_dn_tx;
            end
            if (up_slot_strobe_i) begin
                up_tx_data_o <= next_up_tx;
            end
        end
    end

    // Checks
    tally_increment_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (count_parity && count_crc && !count_icrc && !count_decode && !count_header
         && !wr_tally && bit_error_tally < 8'hFD)
        |=> bit_error_tally == $past(bit_error_tally) + 8'h02)
        else $error("tally did not add both enabled errors");

    tally_clear_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (wr_tally && tally_inc == 3'h0) |=> bit_error_tally == 8'h00)
        else $error("tally not cleared by write");

    tally_disabled_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (error_tally_control == 8'h00 && !wr_tally) |=> $stable(bit_error_tally))
        else $error("tally moved with all error types disabled");

    tally_saturate_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (bit_error_tally == 8'hFF && !wr_tally) |=> bit_error_tally == 8'hFF)
        else $error("tally wrapped");

    mismatch_ro_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (reg_write_i && reg_addr_i >= `REG_MISMATCH_BYTE0
         && reg_addr_i <= `REG_MISMATCH_BYTE3 && mismatch_inc == 3'h0)
        |=> $stable(pattern_mismatch_count))
        else $error("mismatch count changed by write");

    main_upcheck_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (main_node_i && upstream_pattern_enable && up_slot_strobe_i
         && up_rx_data_i != up_expected && !dn_mismatch
         && pattern_mismatch_count < 32'hFFFFFFFF)
        |=> pattern_mismatch_count == $past(pattern_mismatch_count) + 32'h00000001)
        else $error("main node missed an upstream mismatch");

    last_window_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (last_node_i && !main_node_i && downstream_pattern_enable && dn_slot_strobe_i
         && !dn_in_window && !up_mismatch) |=> $stable(pattern_mismatch_count))
        else $error("slot outside window was checked");

    hop_forward_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (!main_node_i && per_hop_check_enable && downstream_pattern_enable
         && dn_slot_strobe_i && dn_in_window)
        |=> dn_tx_data_o == $past(dn_expected))
        else $error("per-hop node forwarded received data");

    hop_inert_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (!any_pattern && up_slot_strobe_i) |=> up_tx_data_o == $past(up_local_data_i))
        else $error("pattern path active with no enable");

    fifo_depth_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (depth_field == 2'h3) ##1 (depth_field == 2'h3)
        |-> recovery_fifo_extra_depth_o == 2'h2)
        else $error("depth field 3 not mapped to two");

    overflow_flag_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (threshold_sel == 3'h0 && !wr_tally && bit_error_tally == 8'h01
         && tally_inc == 3'h1) |=> tally_overflow_flag_o)
        else $error("overflow flag missed at two errors");

    dn_origin_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (main_node_i && downstream_pattern_enable && dn_slot_strobe_i && dn_in_window)
        |=> dn_tx_data_o == $past(dn_expected))
        else $error("main node did not send the downstream pattern");

    up_origin_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (last_node_i && !main_node_i && upstream_pattern_enable && up_slot_strobe_i)
        |=> up_tx_data_o == $past(up_expected))
        else $error("last node did not send the upstream pattern");

    depth_pass_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (depth_field[1] == 1'b0) |=> recovery_fifo_extra_depth_o == $past(depth_field))
        else $error("depth field 0 or 1 not passed through");

    idle_count_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (!downstream_pattern_enable && !upstream_pattern_enable)
        |=> $stable(pattern_mismatch_count))
        else $error("mismatch count moved with no pattern enabled");

    early_flag_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (tally_sum < tally_threshold) |=> !tally_overflow_flag_o)
        else $error("overflow flag below threshold");

    dn_count_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (last_node_i && !main_node_i && downstream_pattern_enable && dn_slot_strobe_i
         && dn_in_window && dn_rx_data_i != dn_expected && !up_mismatch
         && pattern_mismatch_count < 32'hFFFFFFFF)
        |=> pattern_mismatch_count == $past(pattern_mismatch_count) + 32'h00000001)
        else $error("last node missed a downstream mismatch");

    rdata_hold_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !reg_read_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
endmodule : link_test_block

// ==== bench/link_peer_model.sv ====
// Far-side node model: records outgoing pattern words and plays them back
// Assumes the bench raises capture and play with the slot strobes
`timescale 1ns/1ps

module link_peer_model
    import link_test_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       capture_i,
    input  wire slot_word_t tx_word_i,
    input  wire logic       play_i,
    input  wire logic       flip_i,
    output slot_word_t      rx_word_o
);
    slot_word_t rec [0:63];
    int         wr_ptr = 0;
    int         rd_ptr = 0;
    logic       cap_q  = 1'b0;
    slot_word_t idle_q = 32'h5A5A5A5A;

    // Recorded words travel while playing, otherwise a changing idle word
    assign rx_word_o = play_i ? (rec[rd_ptr] ^ {32{flip_i}}) : idle_q;

    always @(posedge clock_i) begin
        cap_q  <= capture_i;
        idle_q <= ~idle_q + 32'h1;
        if (cap_q) begin
            rec[wr_ptr] <= tx_word_i;
            wr_ptr      <= wr_ptr + 1;
        end
        rd_ptr <= play_i ? rd_ptr + 1 : 0;
    end
endmodule : link_peer_model

// ==== bench/tb_top.sv ====
// Self-checking bench of the link self-test block
// Assumes one peer model standing in for the neighbouring nodes
`timescale 1ns/1ps

module tb_top
    import link_test_pkg::*;
;
    logic       clock_i   = 1'b0;
    logic       nrst_i    = 1'b0;
    logic [7:0] reg_addr  = 8'h00;
    logic       reg_write = 1'b0;
    logic       reg_read  = 1'b0;
    reg_byte_t  reg_wdata = 8'h00;
    reg_byte_t  reg_rdata;
    logic       main_node = 1'b0;
    logic       last_node = 1'b0;
    logic [4:0] err_v     = 5'h00;
    logic       flag;
    logic [1:0] depth;
    logic       dn_strobe = 1'b0;
    logic       up_strobe = 1'b0;
    logic [7:0] dn_index  = 8'h00;
    logic [23:0] slot_cnt = 24'h040202;
    slot_word_t dn_local  = 32'h00000000;
    slot_word_t up_local  = 32'h00000000;
    slot_word_t dn_tx;
    slot_word_t up_tx;
    slot_word_t peer_word;
    logic       capture   = 1'b0;
    logic       play_on   = 1'b0;
    logic       flip      = 1'b0;
    int         errors    = 0;
    int         compares  = 0;
    int         pulses    = 0;
    int         ecnt      = 0;
    int         seed      = 56;

    always #12.5 clock_i = ~clock_i;

    always @(posedge clock_i) if (flag === 1'b1) pulses++;

    link_test_block DUT (
        .clock_i(clock_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr),
        .reg_write_i(reg_write), .reg_read_i(reg_read), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .main_node_i(main_node), .last_node_i(last_node),
        .downstream_slot_count_i(slot_cnt[23:16]),
        .local_downstream_slot_count_i(slot_cnt[15:8]),
        .broadcast_downstream_slot_count_i(slot_cnt[7:0]), .parity_error_i(err_v[3]),
        .crc_error_i(err_v[2]), .interrupt_crc_error_i(err_v[4]),
        .decode_error_i(err_v[1]), .header_count_error_i(err_v[0]),
        .tally_overflow_flag_o(flag), .recovery_fifo_extra_depth_o(depth),
        .dn_slot_strobe_i(dn_strobe), .dn_slot_index_i(dn_index),
        .dn_rx_data_i(peer_word), .dn_local_data_i(dn_local), .dn_tx_data_o(dn_tx),
        .up_slot_strobe_i(up_strobe), .up_rx_data_i(peer_word),
        .up_local_data_i(up_local), .up_tx_data_o(up_tx)
    );

    link_peer_model peer (
        .clock_i(clock_i), .capture_i(capture), .tx_word_i(dn_tx),
        .play_i(play_on), .flip_i(flip), .rx_word_o(peer_word)
    );

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock_i);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock_i);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic rdcnt(output logic [31:0] c);
        for (int b = 0; b < 4; b++) rd(8'(8'h21 + b), c[8*b +: 8]);
    endtask : rdcnt

    // Pattern source x^31 + x^28 + 1, 32 bits a word, oldest bit in the msb
    function automatic logic [62:0] prbs_next(input logic [62:0] sw);
        logic [30:0] st;
        logic [31:0] wd;
        st = sw[62:32];
        wd = 32'h00000000;
        repeat (32) begin
            wd = {wd[30:0], st[30] ^ st[27]};
            st = {st[29:0], wd[0]};
        end
        return {st, wd};
    endfunction : prbs_next

    task automatic pulse_err(input int n);
        repeat (n) @(posedge clock_i) err_v <= 5'h08;
        @(posedge clock_i) err_v <= 5'h00;
        repeat (2) @(posedge clock_i);
    endtask : pulse_err

    // Mode 1: forwarded word is the expected one; mode 2: local word passes
    task automatic play(logic [7:0] ctl, logic is_main, logic is_last, logic up,
                        logic rec_run, int mode);
        logic        f;
        slot_word_t  prev;
        logic [31:0] cnt;
        wr(8'h20, 8'h00);
        main_node <= is_main;
        last_node <= is_last;
        wr(8'h20, ctl);
        for (int i = 0; i < 32; i++) begin
            @(posedge clock_i);
            prev = up_local;
            f = !rec_run && (($random(seed) & 3) == 0);
            if (f && ctl[1:0] != 2'b00) ecnt++;
            dn_strobe <= !up;
            up_strobe <= up;
            dn_index  <= 8'(i % 8);
            dn_local  <= $random(seed);
            up_local  <= $random(seed);
            capture   <= rec_run;
            play_on   <= !rec_run;
            flip      <= f;
            @(negedge clock_i);
            if (i > 0 && mode == 1) check("forwarded word", up_tx, peer.rec[i-1]);
            if (i > 0 && mode == 2) check("passed word", up_tx, prev);
        end
        @(posedge clock_i);
        dn_strobe <= 1'b0;
        up_strobe <= 1'b0;
        capture   <= 1'b0;
        play_on   <= 1'b0;
        flip      <= 1'b0;
        repeat (3) @(posedge clock_i);
        rdcnt(cnt);
        check("mismatch count", cnt, 32'(ecnt));
    endtask : play

    initial begin
        logic [7:0]  v;
        logic [7:0]  ctl;
        logic [4:0]  e;
        logic [31:0] cnt;
        int          exp;
        logic [7:0]  regs [8];
        logic [23:0] s;
        slot_word_t  w;
        logic [62:0] pw;
        regs = '{8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h30};
        repeat (6) @(posedge clock_i);
        nrst_i <= 1'b1;
        foreach (regs[k]) begin
            rd(regs[k], v);
            check("reset value", v, 8'h00);
        end
        for (int t = 0; t < 6; t++) begin
            ctl = 8'($random(seed)) & 8'h1F;
            wr(8'h1E, ctl);
            wr(8'h1F, 8'($random(seed)));
            exp = 0;
            repeat (20) begin
                @(posedge clock_i);
                e = 5'($random(seed));
                err_v <= e;
                exp += $countones(e & ctl[4:0]);
            end
            @(posedge clock_i) err_v <= 5'h00;
            rd(8'h1F, v);
            check("tally", v, 8'(exp));
            wr(8'h1F, 8'($random(seed)));
            rd(8'h1F, v);
            check("cleared tally", v, 8'h00);
        end
        for (int k = 0; k < 8; k++) begin
            wr(8'h1E, {3'(k), 5'h08});
            wr(8'h1F, 8'h00);
            pulses = 0;
            pulse_err((2 << k) - 1);
            check("early flag", 32'(pulses), 0);
            pulse_err(1);
            rd(8'h1F, v);
            check("flag", 32'(pulses), 1);
            check("saturated tally", v, k == 7 ? 8'hFF : 8'(2 << k));
        end
        for (int d = 0; d < 4; d++) begin
            wr(8'h20, {2'b00, 2'(d), 4'h0});
            rd(8'h20, v);
            check("control readback", v, {2'b00, 2'(d), 4'h0});
            check("fifo depth", depth, d > 1 ? 2'h2 : 2'(d));
        end
        play(8'h02, 1'b1, 1'b0, 1'b0, 1'b1, 0);
        check("first pattern word", peer.rec[0], 32'h00000000);
        check("pattern running", peer.rec[1] != 32'h00000000, 1);
        pw = {31'h7FFFFFFF, 32'h00000000};
        for (int j = 0; j < 32; j++) begin
            check("pattern word", peer.rec[j], pw[31:0]);
            pw = prbs_next(pw);
        end
        main_node <= 1'b0;
        last_node <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clock_i);
            s = 24'($random(seed)) & 24'h3F3F3F;
            slot_cnt  <= s;
            dn_strobe <= 1'b1;
            dn_index  <= s[23:16] + s[15:8] + s[7:0] + 8'(k);
            dn_local  <= $random(seed);
            @(negedge clock_i) w = peer_word;
            @(posedge clock_i) dn_strobe <= 1'b0;
            @(negedge clock_i);
            check("outside window", dn_tx, w);
        end
        slot_cnt <= 24'h040202;
        play(8'h01, 1'b1, 1'b0, 1'b1, 1'b0, 0);
        play(8'h02, 1'b0, 1'b1, 1'b0, 1'b0, 0);
        play(8'h05, 1'b0, 1'b0, 1'b1, 1'b0, 1);
        play(8'h04, 1'b0, 1'b0, 1'b1, 1'b0, 2);
        play(8'h01, 1'b0, 1'b1, 1'b1, 1'b1, 1);
        for (int b = 0; b < 4; b++) wr(8'(8'h21 + b), 8'hFF);
        rdcnt(cnt);
        check("read-only count", cnt, 32'(ecnt));
        conclude();
    end

    initial begin
        #500000;
        errors++;
        conclude();
    end
endmodule : tb_top
